// ### tsi_defines.svh
// Constants for the time-slot interchange switch pin interface
`ifndef TSI_DEFINES_SVH
`define TSI_DEFINES_SVH

// ==========================================================
// Stream and frame geometry
`define TSI_STREAMS 8
`define TSI_CHANNELS 128
`define TSI_BITS_PER_CH 8
`define TSI_INDEX_W 10
`define TSI_FRAME_LAST_BIT 10'h3FF
`define TSI_CH_LAST_BIT 3'h7
`define TSI_FETCH_AHEAD 7'h02

// ==========================================================
// Clock rates and timing
`define TSI_SCLK_HZ 16384000
`define TSI_SCLK_PER_BIT 2
`define TSI_BIT_RATE_HZ (`TSI_SCLK_HZ / `TSI_SCLK_PER_BIT)
`define TSI_ALIGN_HZ 4096000
`define TSI_PULSE_MAX_EDGES 4'h4
`define TSI_CLK_PERIOD_NS 8
`define TSI_RESET_MIN_NS 100
`define TSI_RESET_MIN_CYCLES ((`TSI_RESET_MIN_NS + `TSI_CLK_PERIOD_NS - 1) / `TSI_CLK_PERIOD_NS)

// ==========================================================
// Microport locations
`define UP_PTR_ADDR 8'h00
`define UP_CONN_ADDR 8'h01
`define UP_DATA_ADDR 8'h02
`define UP_STAT_ADDR 8'h03
`define UP_READ_IDLE 16'h0000

// ==========================================================
// Connection entry fields
`define CM_WIDTH 12
`define CM_SRC_MSB 9
`define CM_CONST_BIT 10
`define CM_OE_BIT 11

`endif

// ### tsi_pkg.sv
// Types shared by the switch pin interface modules
`include "tsi_defines.svh"
package tsi_pkg;
  typedef enum logic [1:0] {BUS_NONMUX, BUS_MUX_STROBE, BUS_MUX_RDWR} bus_style_e;
  typedef logic [`TSI_INDEX_W-1:0] chan_idx_t;
  typedef logic [`CM_WIDTH-1:0] conn_entry_t;
endpackage

// ### serial_in_conv.sv
// Serial to parallel converter for one input stream
`timescale 1ns/100ps
`default_nettype none
`include "tsi_defines.svh"
module serial_in_conv #(
  parameter int BITS = `TSI_BITS_PER_CH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic bitEn,
  input wire logic lastBit,
  input wire logic serialIn,
  output logic [BITS-1:0] rxByte
);
  logic [BITS-1:0] shift_q, shift_d, hold_q, hold_d;

  // ==========================================================
  // Shift in MSB first, hold the byte for a whole channel
  always_comb begin
    shift_d = shift_q;
    hold_d = hold_q;
    if (bitEn) begin
      shift_d = {shift_q[BITS-2:0], serialIn};
      if (lastBit) begin
        hold_d = {shift_q[BITS-2:0], serialIn};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift_q <= '0;
      hold_q <= '0;
    end else begin
      shift_q <= shift_d;
      hold_q <= hold_d;
    end
  end

  assign rxByte = hold_q;
endmodule
`default_nettype wire

// ### serial_out_conv.sv
// Parallel to serial converter for one three-state output stream
`timescale 1ns/100ps
`default_nettype none
`include "tsi_defines.svh"
module serial_out_conv #(
  parameter int BITS = `TSI_BITS_PER_CH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic bitEn,
  input wire logic load,
  input wire logic [BITS-1:0] loadByte,
  input wire logic loadOe,
  output logic serialOut,
  output logic serialOutOe
);
  logic [BITS-1:0] shift_q, shift_d;
  logic oe_q, oe_d;

  // ==========================================================
  // Load on channel boundary, otherwise shift one bit per bit slot
  always_comb begin
    shift_d = shift_q;
    oe_d = oe_q;
    if (load) begin
      shift_d = loadByte;
      oe_d = loadOe;
    end else if (bitEn) begin
      shift_d = {shift_q[BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift_q <= '0;
      oe_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      oe_q <= oe_d;
    end
  end

  // Reset gates the enable at once, not one edge later
  assign serialOut = shift_q[BITS-1];
  assign serialOutOe = oe_q & rstn;
endmodule
`default_nettype wire

// ### tsi_switch_pin_interface.sv
// Time-slot interchange switch: stream timing, switching memories and microport
// Contract
// - Any of 1024 input channels switches to any output channel, never blocked.
// - Eight input streams are sampled at 8.192 Mb/s.
// - Eight output streams are driven at 8.192 Mb/s as three-state outputs.
// - A 16.384 MHz serial clock paces all input and output shifting.
// - Wide-pulse select high gives wide pulse alignment, low gives standard framing.
// - With wide-pulse select low, pulse polarity picks standard or GCI format.
// - With wide-pulse select high, frame sync is an active-low wide pulse.
// - Shared pin measures frame offset, or is 4.096 MHz alignment clock.
// - Reset clears counters and registers and floats streams and data bus.
// - Non-multiplexed accesses take their address from eight address lines.
// - Multiplexed strobe style uses active-high data strobe with chip select.
// - Non-multiplexed mode uses active-low data strobe with chip select.
// - Multiplexed read strobe low makes the device drive the data bus.
// - In strobe styles the read/write pin sets data bus direction.
// - Multiplexed write strobe low with read strobe high makes the bus inputs.
// - Each channel selects variable or constant throughput delay.
// - Port accesses are ignored while chip select is inactive.
// - Mode pin high selects multiplexed port, low selects non-multiplexed.
`timescale 1ns/100ps
`default_nettype none
`include "tsi_defines.svh"
module tsi_switch_pin_interface (
  input wire logic clk,
  input wire logic rstn,
  input wire logic serialClk,
  input wire logic [`TSI_STREAMS-1:0] serialInStreams,
  output logic [`TSI_STREAMS-1:0] serialOutStreams,
  output logic [`TSI_STREAMS-1:0] serialOutOe,
  input wire logic frameSyncIn,
  input wire logic frameMeasureOrAlignClock,
  input wire logic widePulseSelect,
  input wire logic busMuxSelect,
  input wire logic csN,
  input wire logic addrStrobe,
  input wire logic strobeOrReadPin,
  input wire logic rwPin,
  input wire logic [7:0] addrLines,
  input wire logic [7:0] muxedAddrDataLowIn,
  output logic [7:0] muxedAddrDataLowOut,
  output logic muxedAddrDataLowOe,
  input wire logic [7:0] dataHighByteIn,
  output logic [7:0] dataHighByteOut,
  output logic dataHighByteOe,
  output logic gciDetected,
  output var tsi_pkg::chan_idx_t frameMeasureCount,
  output logic frameMeasureValid
);
  import tsi_pkg::*;

  localparam int NS = `TSI_STREAMS;
  localparam int MEM_WORDS = NS * `TSI_CHANNELS;

  // ==========================================================
  // Stream timing
  logic sclkPrev_q, sclkPrev_d, alignPrev_q, alignPrev_d, phase_q, phase_d;
  logic fsLevel_q, fsLevel_d, fsAlign_q, fsAlign_d, gci_q, gci_d, curBank_q, curBank_d;
  logic [3:0] fsRun_q, fsRun_d;
  chan_idx_t bitCount_q, bitCount_d, measCount_q, measCount_d;
  logic measValid_q, measValid_d;
  logic sclkRise, alignRise, fsEdge, shortPulse, frameStart, bitEn, chEnd;

  // Bit slot is two serial clock edges; a frame pulse restarts the count
  always_comb begin
    sclkRise = serialClk & ~sclkPrev_q;
    alignRise = frameMeasureOrAlignClock & ~alignPrev_q;
    sclkPrev_d = serialClk;
    alignPrev_d = frameMeasureOrAlignClock;
    fsEdge = sclkRise && (frameSyncIn != fsLevel_q);
    shortPulse = fsRun_q < `TSI_PULSE_MAX_EDGES;
    fsLevel_d = sclkRise ? frameSyncIn : fsLevel_q;
    fsAlign_d = alignRise ? frameSyncIn : fsAlign_q;
    fsRun_d = fsRun_q;
    if (fsEdge) begin
      fsRun_d = 4'h0;
    end else if (sclkRise && fsRun_q != 4'hF) begin
      fsRun_d = fsRun_q + 4'h1;
    end
    // Wide mode: frame starts where the low pulse ends on an alignment edge
    if (widePulseSelect) begin
      frameStart = alignRise & ~fsAlign_q & frameSyncIn;
    end else begin
      frameStart = fsEdge & shortPulse;
    end
    // Short low pulse means standard format, short high pulse means GCI
    gci_d = (!widePulseSelect && fsEdge && shortPulse) ? fsLevel_q : gci_q;
    // The last bit of a frame falls on the restarting rise, so it is kept
    bitEn = sclkRise & phase_q;
    chEnd = bitEn && (bitCount_q[2:0] == `TSI_CH_LAST_BIT);
    phase_d = phase_q;
    bitCount_d = bitCount_q;
    curBank_d = curBank_q;
    if (frameStart) begin
      phase_d = 1'b0;
      bitCount_d = '0;
      if (bitEn && bitCount_q == `TSI_FRAME_LAST_BIT) begin
        curBank_d = ~curBank_q;
      end
    end else if (sclkRise) begin
      phase_d = ~phase_q;
      if (bitEn) begin
        bitCount_d = bitCount_q + 10'h001;
        if (bitCount_q == `TSI_FRAME_LAST_BIT) begin
          curBank_d = ~curBank_q;
        end
      end
    end
    // Offset measurement only while the shared pin is not a clock
    measCount_d = measCount_q;
    measValid_d = 1'b0;
    if (!widePulseSelect && alignPrev_q && !frameMeasureOrAlignClock) begin
      measCount_d = bitCount_q;
      measValid_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sclkPrev_q <= 1'b0;
      alignPrev_q <= 1'b0;
      phase_q <= 1'b0;
      fsLevel_q <= 1'b1;
      fsAlign_q <= 1'b1;
      gci_q <= 1'b0;
      curBank_q <= 1'b0;
      fsRun_q <= 4'hF;
      bitCount_q <= '0;
      measCount_q <= '0;
      measValid_q <= 1'b0;
    end else begin
      sclkPrev_q <= sclkPrev_d;
      alignPrev_q <= alignPrev_d;
      phase_q <= phase_d;
      fsLevel_q <= fsLevel_d;
      fsAlign_q <= fsAlign_d;
      gci_q <= gci_d;
      curBank_q <= curBank_d;
      fsRun_q <= fsRun_d;
      bitCount_q <= bitCount_d;
      measCount_q <= measCount_d;
      measValid_q <= measValid_d;
    end
  end

  assign gciDetected = gci_q;
  assign frameMeasureCount = measCount_q;
  assign frameMeasureValid = measValid_q;

  // ==========================================================
  // Memories: two data banks so constant delay reads a whole old frame
  logic [7:0] dataMem [0:2*MEM_WORDS-1];
  conn_entry_t connMem [0:MEM_WORDS-1];
  logic [MEM_WORDS-1:0] connValid_q, connValid_d;
  logic [7:0] rxByte [0:NS-1];

  // ==========================================================
  // Input write sequencer: one stream per cycle after each channel
  logic wrBusy_q, wrBusy_d, wrBank_q, wrBank_d;
  logic [2:0] wrIdx_q, wrIdx_d;
  logic [6:0] wrCh_q, wrCh_d;

  always_comb begin
    wrBusy_d = wrBusy_q;
    wrIdx_d = wrIdx_q;
    wrCh_d = wrCh_q;
    wrBank_d = wrBank_q;
    if (chEnd) begin
      wrBusy_d = 1'b1;
      wrIdx_d = 3'h0;
      wrCh_d = bitCount_q[9:3];
      wrBank_d = curBank_q;
    end else if (wrBusy_q) begin
      wrIdx_d = wrIdx_q + 3'h1;
      wrBusy_d = (wrIdx_q != 3'h7);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrBusy_q <= 1'b0;
      wrIdx_q <= 3'h0;
      wrCh_q <= 7'h00;
      wrBank_q <= 1'b0;
    end else begin
      wrBusy_q <= wrBusy_d;
      wrIdx_q <= wrIdx_d;
      wrCh_q <= wrCh_d;
      wrBank_q <= wrBank_d;
    end
  end

  // Data memory write port
  always_ff @(posedge clk) begin
    if (wrBusy_q) begin
      dataMem[{wrBank_q, wrIdx_q, wrCh_q}] <= rxByte[wrIdx_q];
    end
  end

  // ==========================================================
  // Output fetch: prepares the channel after next, all eight streams
  logic fetchBusy_q, fetchBusy_d;
  logic [2:0] fetchIdx_q, fetchIdx_d;
  logic [6:0] fetchCh_q, fetchCh_d;
  logic [7:0] nextByte_q [0:NS-1];
  logic [7:0] nextByte_d [0:NS-1];
  logic [NS-1:0] nextOe_q, nextOe_d;
  conn_entry_t connEntry;
  logic fetchConst, fetchBank;
  logic [7:0] fetchByte;

  always_comb begin
    connEntry = connMem[{fetchIdx_q, fetchCh_q}];
    fetchConst = connEntry[`CM_CONST_BIT];
    // Variable delay takes this frame's byte only once it is surely stored;
    // the channel just ended is still being written while we fetch
    if (fetchConst) begin
      fetchBank = ~curBank_q;
    end else if (({1'b0, connEntry[6:0]} + 8'h01) < {1'b0, bitCount_q[9:3]}) begin
      fetchBank = curBank_q;
    end else begin
      fetchBank = ~curBank_q;
    end
    fetchByte = dataMem[{fetchBank, connEntry[`CM_SRC_MSB:0]}];
    fetchBusy_d = fetchBusy_q;
    fetchIdx_d = fetchIdx_q;
    fetchCh_d = fetchCh_q;
    nextByte_d = nextByte_q;
    nextOe_d = nextOe_q;
    if (chEnd) begin
      fetchBusy_d = 1'b1;
      fetchIdx_d = 3'h0;
      fetchCh_d = bitCount_q[9:3] + `TSI_FETCH_AHEAD;
    end else if (fetchBusy_q) begin
      // Unconnected channels idle low instead of showing stale memory
      nextByte_d[fetchIdx_q] = connValid_q[{fetchIdx_q, fetchCh_q}] ? fetchByte : 8'h00;
      nextOe_d[fetchIdx_q] = connValid_q[{fetchIdx_q, fetchCh_q}] & connEntry[`CM_OE_BIT];
      fetchIdx_d = fetchIdx_q + 3'h1;
      fetchBusy_d = (fetchIdx_q != 3'h7);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fetchBusy_q <= 1'b0;
      fetchIdx_q <= 3'h0;
      fetchCh_q <= 7'h00;
      nextOe_q <= '0;
      for (int i = 0; i < NS; i++) begin
        nextByte_q[i] <= 8'h00;
      end
    end else begin
      fetchBusy_q <= fetchBusy_d;
      fetchIdx_q <= fetchIdx_d;
      fetchCh_q <= fetchCh_d;
      nextOe_q <= nextOe_d;
      nextByte_q <= nextByte_d;
    end
  end

  // Per-stream converters
  genvar g;
  for (g = 0; g < NS; g++) begin : g_stream
    serial_in_conv u_in (
      .clk(clk),
      .rstn(rstn),
      .bitEn(bitEn),
      .lastBit(chEnd),
      .serialIn(serialInStreams[g]),
      .rxByte(rxByte[g])
    );
    serial_out_conv u_out (
      .clk(clk),
      .rstn(rstn),
      .bitEn(bitEn),
      .load(chEnd),
      .loadByte(nextByte_q[g]),
      .loadOe(nextOe_q[g]),
      .serialOut(serialOutStreams[g]),
      .serialOutOe(serialOutOe[g])
    );
  end

  // ==========================================================
  // Microport: style decode, address latch, pointer and reads
  bus_style_e muxStyle_q, muxStyle_d, busStyle;
  logic asPrev_q, asPrev_d, wrActive_q, wrActive_d, rdOe_q, rdOe_d;
  logic [7:0] latAddr_q, latAddr_d, accAddr;
  chan_idx_t ptr_q, ptr_d;
  logic [15:0] rdData_q, rdData_d, readWord, wrWord;
  logic rdActive, wrActive, memWrite;

  always_comb begin
    asPrev_d = addrStrobe;
    latAddr_d = addrStrobe ? muxedAddrDataLowIn : latAddr_q;
    // Idle read strobe high at latch time marks the read/write strobe style
    muxStyle_d = muxStyle_q;
    if (asPrev_q && !addrStrobe) begin
      muxStyle_d = strobeOrReadPin ? BUS_MUX_RDWR : BUS_MUX_STROBE;
    end
    busStyle = busMuxSelect ? muxStyle_q : BUS_NONMUX;
    accAddr = busMuxSelect ? latAddr_q : addrLines;
    rdActive = 1'b0;
    wrActive = 1'b0;
    case (busStyle)
      BUS_NONMUX: begin
        rdActive = !csN && !strobeOrReadPin && rwPin;
        wrActive = !csN && !strobeOrReadPin && !rwPin;
      end
      BUS_MUX_STROBE: begin
        rdActive = !csN && strobeOrReadPin && rwPin;
        wrActive = !csN && strobeOrReadPin && !rwPin;
      end
      BUS_MUX_RDWR: begin
        rdActive = !csN && !strobeOrReadPin;
        wrActive = !csN && !rwPin && strobeOrReadPin;
      end
      default: begin
        rdActive = 1'b0;
        wrActive = 1'b0;
      end
    endcase
    wrActive_d = wrActive;
    memWrite = wrActive & ~wrActive_q;
    wrWord = {dataHighByteIn, muxedAddrDataLowIn};
    ptr_d = ptr_q;
    connValid_d = connValid_q;
    if (memWrite && accAddr == `UP_PTR_ADDR) begin
      ptr_d = wrWord[`TSI_INDEX_W-1:0];
    end
    if (memWrite && accAddr == `UP_CONN_ADDR) begin
      connValid_d[ptr_q] = 1'b1;
    end
    case (accAddr)
      `UP_PTR_ADDR: readWord = {6'h00, ptr_q};
      `UP_CONN_ADDR: readWord = connValid_q[ptr_q] ? {4'h0, connMem[ptr_q]} : 16'h0000;
      `UP_DATA_ADDR: readWord = {8'h00, dataMem[{~curBank_q, ptr_q}]};
      `UP_STAT_ADDR: readWord = {4'h0, gci_q, curBank_q, bitCount_q};
      default: readWord = `UP_READ_IDLE;
    endcase
    rdData_d = rdActive ? readWord : rdData_q;
    rdOe_d = rdActive;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      muxStyle_q <= BUS_MUX_STROBE;
      asPrev_q <= 1'b0;
      wrActive_q <= 1'b0;
      rdOe_q <= 1'b0;
      latAddr_q <= 8'h00;
      ptr_q <= '0;
      rdData_q <= 16'h0000;
      connValid_q <= '0;
    end else begin
      muxStyle_q <= muxStyle_d;
      asPrev_q <= asPrev_d;
      wrActive_q <= wrActive_d;
      rdOe_q <= rdOe_d;
      latAddr_q <= latAddr_d;
      ptr_q <= ptr_d;
      rdData_q <= rdData_d;
      connValid_q <= connValid_d;
    end
  end

  // Connection memory write port
  always_ff @(posedge clk) begin
    if (memWrite && accAddr == `UP_CONN_ADDR) begin
      connMem[ptr_q] <= wrWord[`CM_WIDTH-1:0];
    end
  end

  // Drive only from the second read cycle, so data is already registered
  assign muxedAddrDataLowOut = rdData_q[7:0];
  assign dataHighByteOut = rdData_q[15:8];
  assign muxedAddrDataLowOe = rdOe_q & rdActive & rstn;
  assign dataHighByteOe = rdOe_q & rdActive & rstn;

  // ==========================================================
  // Assertions
  logic [1:0] edgesSinceBit_q;
  always_ff @(posedge clk) begin
    if (!rstn || bitEn || frameStart) begin
      edgesSinceBit_q <= 2'h0;
    end else if (sclkRise && edgesSinceBit_q != 2'h3) begin
      edgesSinceBit_q <= edgesSinceBit_q + 2'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_fetch_run;
    fetchBusy_q [*8] ##1 !fetchBusy_q;
  endsequence
  sequence s_read_held;
    rdActive ##1 rdActive;
  endsequence

  property p_reset_hiz;
    @(posedge clk) disable iff (1'b0)
    !rstn |-> (serialOutOe == '0) && !muxedAddrDataLowOe && !dataHighByteOe;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("outputs driven in reset");
  property p_bit_rate;
    bitEn |-> edgesSinceBit_q == 2'h1;
  endproperty
  a_bit_rate: assert property (p_bit_rate) else $error("bit slot not two clocks");
  property p_out_stable;
    !bitEn |=> $stable(serialOutStreams);
  endproperty
  a_out_stable: assert property (p_out_stable) else $error("output moved off slot");
  property p_fetch_all;
    chEnd |=> s_fetch_run;
  endproperty
  a_fetch_all: assert property (p_fetch_all) else $error("fetch missed streams");
  property p_wide_align;
    widePulseSelect && frameStart |-> alignRise ##1 (bitCount_q == '0) && !phase_q;
  endproperty
  a_wide_align: assert property (p_wide_align) else $error("wide frame off clock");
  property p_auto_detect;
    !widePulseSelect && frameStart |=> gciDetected == $past(fsLevel_q);
  endproperty
  a_auto_detect: assert property (p_auto_detect) else $error("format misdetected");
  property p_cs_ignore;
    csN |-> !muxedAddrDataLowOe && !memWrite;
  endproperty
  a_cs_ignore: assert property (p_cs_ignore) else $error("access without select");
  property p_read_drive;
    s_read_held |-> muxedAddrDataLowOe && dataHighByteOe;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");
  property p_write_once;
    wrActive && wrActive_q |-> !memWrite && !muxedAddrDataLowOe;
  endproperty
  a_write_once: assert property (p_write_once) else $error("write repeated");
  property p_addr_src;
    (!busMuxSelect |-> accAddr == addrLines) and (busMuxSelect |-> accAddr == latAddr_q) and
      ($fell(addrStrobe) |-> latAddr_q == $past(muxedAddrDataLowIn));
  endproperty
  a_addr_src: assert property (p_addr_src) else $error("wrong address source");
  property p_const_delay;
    fetchBusy_q && fetchConst |-> fetchBank != curBank_q;
  endproperty
  a_const_delay: assert property (p_const_delay) else $error("constant delay bank");
endmodule
`default_nettype wire

// ### tsi_switch_pin_interface_end.sv
// Empty companion unit of the switch pin interface; holds no logic
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### tdm_peer.sv
// Far-side model: serial clock, frame sync and input stream peers
`timescale 1ns/100ps
`default_nettype none
module tdm_peer (
  input wire logic clk,
  input wire logic gciMode,
  input wire logic wideMode,
  input wire logic measLvl,
  output logic serialClk,
  output logic frameSync,
  output logic measOrAlign,
  output logic [7:0] serialIn
);
  int tick;
  int hTick;
  int rises;
  logic alignClk;
  // ==========================================
  // Clocks
  initial begin
    tick = 0;
    hTick = 0;
    rises = 0;
    alignClk = 1'b0;
    serialClk = 1'b0;
  end
  // Near 16.384 and 4.096 MHz from the 125 MHz clock; close enough for a model
  always @(negedge clk) begin
    tick = tick + 1;
    hTick = hTick + 1;
    if (tick == 4) begin
      tick = 0;
      if (!serialClk) rises = (rises + 1) % 2048;
      serialClk <= !serialClk;
    end
    if (hTick == 15) begin
      hTick = 0;
      alignClk <= !alignClk;
    end
  end
  // ==========================================
  // Frame sync: short pulse of either polarity, or a wide low pulse
  assign frameSync = wideMode ? (rises >= 16) : (gciMode ? (rises < 2) : (rises >= 2));
  assign measOrAlign = wideMode ? alignClk : measLvl;
  // Data changes every second serial rise, one bit slot
  assign serialIn = 8'hA5 ^ {8{rises[1]}};
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the switch pin interface
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rstn, csN, addrStrobe, strobeOrReadPin, rwPin, busMuxSelect;
  logic gciMode, wideMode, measLvl, serialClk, frameSyncIn, frameMeasureOrAlignClock;
  logic [7:0] serialInStreams, serialOutStreams, serialOutOe, addrLines;
  logic [7:0] muxedAddrDataLowIn, muxedAddrDataLowOut, dataHighByteIn, dataHighByteOut;
  logic muxedAddrDataLowOe, dataHighByteOe, gciDetected, frameMeasureValid;
  tsi_pkg::chan_idx_t frameMeasureCount;
  int bad_count = 0;
  int tests_run = 0;
  logic [15:0] rd;
  logic hit;
  tsi_switch_pin_interface dut_u (.clk(clk), .rstn(rstn), .serialClk(serialClk),
    .serialInStreams(serialInStreams), .serialOutStreams(serialOutStreams),
    .serialOutOe(serialOutOe), .frameSyncIn(frameSyncIn),
    .frameMeasureOrAlignClock(frameMeasureOrAlignClock), .widePulseSelect(wideMode),
    .busMuxSelect(busMuxSelect), .csN(csN), .addrStrobe(addrStrobe),
    .strobeOrReadPin(strobeOrReadPin), .rwPin(rwPin), .addrLines(addrLines),
    .muxedAddrDataLowIn(muxedAddrDataLowIn), .muxedAddrDataLowOut(muxedAddrDataLowOut),
    .muxedAddrDataLowOe(muxedAddrDataLowOe), .dataHighByteIn(dataHighByteIn),
    .dataHighByteOut(dataHighByteOut), .dataHighByteOe(dataHighByteOe),
    .gciDetected(gciDetected), .frameMeasureCount(frameMeasureCount),
    .frameMeasureValid(frameMeasureValid));
  tdm_peer peer_u (.clk(clk), .gciMode(gciMode), .wideMode(wideMode), .measLvl(measLvl),
    .serialClk(serialClk), .frameSync(frameSyncIn), .measOrAlign(frameMeasureOrAlignClock),
    .serialIn(serialInStreams));
  // ==========================================
  // Clock and shared tasks
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One port access; md 0 non-muxed, 1 muxed strobe style, 2 muxed read/write strobes
  task automatic acc(input int md, input bit wr, input bit sel, input logic [7:0] a,
                     input logic [15:0] wd, output logic [15:0] q);
    @(negedge clk);
    busMuxSelect = (md != 0);
    addrLines = (md != 0) ? ~a : a;
    if (md != 0) begin
      muxedAddrDataLowIn = a;
      addrStrobe = 1'b1;
      strobeOrReadPin = (md == 2);
      @(negedge clk);
      addrStrobe = 1'b0;
      @(negedge clk);
    end
    {dataHighByteIn, muxedAddrDataLowIn} = wd;
    csN = !sel;
    rwPin = !wr;
    strobeOrReadPin = (md == 1) ? 1'b1 : ((md == 2) ? wr : 1'b0);
    @(negedge clk);
    if (!wr) begin
      @(negedge clk);
      chk("read drive", {14'h0, muxedAddrDataLowOe, dataHighByteOe}, sel ? 16'h0003 : 16'h0000);
      q = {dataHighByteOut, muxedAddrDataLowOut};
    end
    csN = 1'b1;
    rwPin = 1'b1;
    strobeOrReadPin = (md != 1);
    #1;
    chk("bus release", {14'h0, muxedAddrDataLowOe, dataHighByteOe}, 16'h0000);
  endtask
  // Bounded wait on one of the observed flags
  task automatic waitSig(input int s, input int lim, output logic got);
    got = 1'b0;
    repeat (lim) begin
      @(negedge clk);
      if ((s == 0 && serialOutOe[0] === 1'b1) || (s == 1 && gciDetected === 1'b1) ||
          (s == 2 && frameMeasureValid === 1'b1)) begin
        got = 1'b1;
        break;
      end
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_port;
    acc(0, 1, 1, 8'h00, 16'h0155, rd);
    acc(0, 0, 1, 8'h00, 16'h0000, rd);
    chk("pointer", rd, 16'h0155);
    acc(0, 1, 0, 8'h00, 16'h0022, rd);
    acc(0, 0, 0, 8'h00, 16'h0000, rd);
    acc(0, 0, 1, 8'h00, 16'h0000, rd);
    chk("deselected write", rd, 16'h0155);
    acc(0, 0, 1, 8'h7F, 16'h0000, rd);
    chk("unmapped", rd, 16'h0000);
    $display("test port done");
  endtask
  task automatic t_mux;
    acc(1, 1, 1, 8'h00, 16'h02AA, rd);
    acc(1, 0, 1, 8'h00, 16'h0000, rd);
    chk("strobe style", rd, 16'h02AA);
    acc(2, 1, 1, 8'h00, 16'h00AB, rd);
    acc(2, 0, 1, 8'h00, 16'h0000, rd);
    chk("rd wr style", rd, 16'h00AB);
    $display("test mux done");
  endtask
  task automatic t_conn;
    chk("no entries", {8'h00, serialOutOe}, 16'h0000);
    acc(0, 1, 1, 8'h00, 16'h0000, rd);
    acc(0, 1, 1, 8'h01, 16'h0C05, rd);
    acc(0, 0, 1, 8'h01, 16'h0000, rd);
    chk("conn entry", rd, 16'h0C05);
    waitSig(0, 40000, hit);
    chk("stream drive", {15'h0, hit}, 16'h0001);
    $display("test conn done");
  endtask
  // Constant delay needs two stored frames before the switched byte is known
  task automatic t_data;
    logic [7:0] got;
    got = 8'h00;
    repeat (32768) @(negedge clk);
    while (serialOutOe[0] === 1'b1) @(negedge clk);
    waitSig(0, 17000, hit);
    repeat (8) begin
      got = {got[6:0], serialOutStreams[0]};
      repeat (16) @(negedge clk);
    end
    chk("switched byte", {8'h00, got}, 16'h00AA);
    $display("test data done");
  endtask
  task automatic t_frame;
    int expPos;
    chk("std frame", {15'h0, gciDetected}, 16'h0000);
    gciMode = 1'b1;
    waitSig(1, 40000, hit);
    chk("gci frame", {15'h0, hit}, 16'h0001);
    // Drop the measure pin just after a serial rise, so the bit position is known
    repeat (200) @(negedge clk);
    @(posedge serialClk);
    @(negedge clk);
    expPos = ((peer_u.rises + 2046) % 2048) / 2;
    measLvl = 1'b0;
    waitSig(2, 8, hit);
    chk("measure", {15'h0, hit}, 16'h0001);
    chk("measure position", {6'h00, frameMeasureCount}, 16'(expPos));
    measLvl = 1'b1;
    wideMode = 1'b1;
    // Long enough for one wide frame pulse to restart the frame
    waitSig(2, 18000, hit);
    chk("wide no measure", {15'h0, hit}, 16'h0000);
    $display("test frame done");
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    rstn = 1'b0;
    csN = 1'b1;
    addrStrobe = 1'b0;
    strobeOrReadPin = 1'b1;
    rwPin = 1'b1;
    busMuxSelect = 1'b0;
    addrLines = 8'h00;
    muxedAddrDataLowIn = 8'h00;
    dataHighByteIn = 8'h00;
    gciMode = 1'b0;
    wideMode = 1'b0;
    measLvl = 1'b1;
    repeat (13) @(negedge clk);
    chk("reset float", {serialOutOe, 6'h0, muxedAddrDataLowOe, dataHighByteOe}, 16'h0000);
    rstn = 1'b1;
    @(negedge clk);
    t_port;
    t_mux;
    t_conn;
    t_data;
    t_frame;
    summarize;
  end
  // About five frames of waiting plus port traffic end well before this bound, when the last wait is done
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    summarize;
  end
endmodule
`default_nettype wire
